// >>> wbc_consts.svh
`ifndef WBC_CONSTS_SVH
`define WBC_CONSTS_SVH
`define WBC_ADDR_W 28
`define WBC_LINES 16
`define WBC_IDX_W 4
`define WBC_SCAN_MIN_CLKS 4100
`define WBC_CLK_MHZ 20
`define WBC_BE_FIRST 4'h7
`define WBC_BE_SECOND 4'hd
`define WBC_SPECIAL_ADDR_WB 28'h0000000
`define WBC_SPECIAL_ADDR_FA 28'h0000001
`define WBC_BURST_WORDS 3'h4
`define WBC_SNOOP_LATE_CLKS 2
`endif

// >>> wbc_pkg.sv
package wbc_pkg;
  typedef enum logic [2:0] {
    WBC_CYC_NONE,
    WBC_CYC_FILL,
    WBC_CYC_COPYBACK,
    WBC_CYC_SPECIAL,
    WBC_CYC_NONCACHE
  } wbc_cyc_type;
endpackage

// >>> wbc_sync.sv
`timescale 1ns/1ps
module wbc_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  logic s1_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

// >>> wbc_scan_timer.sv
`timescale 1ns/1ps
`include "wbc_consts.svh"
module wbc_scan_timer #(
  parameter int SCAN_CLKS = `WBC_SCAN_MIN_CLKS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  output logic done
);
  logic [12:0] cnt_q;
  logic run_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 13'h0000;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 13'h0000;
      run_q <= 1'b1;
    end else if (run_q && cnt_q != 13'(SCAN_CLKS - 1)) begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end
  assign done = run_q && (cnt_q == 13'(SCAN_CLKS - 1));
endmodule

// >>> wbc_top.sv
`timescale 1ns/1ps
`include "wbc_consts.svh"
// Overview of operation
// - Snoop hitting fill address: pass data to core, never store line.
// - Other-address fill dropped if snoop between strobe and first ready, or last.
// - Copy-back address snoopable until last ready, snoop two clocks before hits.
// - Snoop matching copy-back after strobe and first ready raises modified hit.
// - Modified hit holds through final ready of that copy-back.
// - Write-back-invalidate: copy back, invalidate, write-back then flush cycles.
// - Plain invalidate: drop all lines, flush special cycle only.
// - Write-back special cycle: address zero, data/code low, write, enables 0111.
// - Flush special cycle: address zero, data/code low, write, enables 1101.
// - Write-back-invalidate scan lasts at least 4100 clocks, reset-only abort.
// - Flush pin: copy back, then acknowledges at address one, 0111 then 1101.
// - Hardware flush lasts at least 4100 clocks, reset-only abort.
// - Snoops taken during flush; copy-back resumes afterwards.
// - Burst copy-back is four words starting at line offset zero.
// - Cache indicator active for cacheable reads and copy-backs only.
// - Indicator valid with strobe until ready; floats after backoff and hold ack.
// - Indicator floats in write-through mode.
// - Burst write starts strobe, memory, write, indicator; indicator drops after ready.
// - Last-transfer high mid burst; burst ends on last low with burst ready.
// - Non-burst ready ends bursting, remaining words as single cycles.
// - Backoff leaves bus on the third clock after the pin (synchronised); copy-back resumes from aborted word.
module wbc_top #(
  parameter int SCAN_CLKS = `WBC_SCAN_MIN_CLKS
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic WRITEBACK_MODE,
  input wire logic WRITEBACK_INVALIDATE_INSTR,
  input wire logic INVALIDATE_INSTR,
  input wire logic FLUSH_N,
  input wire logic FILL_REQ,
  input wire logic [`WBC_ADDR_W-1:0] FILL_LINE_ADDR,
  input wire logic FILL_CACHEABLE,
  input wire logic CACHEABLE_ENABLE_IN_N,
  output logic FILL_DATA_VALID,
  output logic FILL_STORE,
  output logic FILL_DISCARD,
  output logic [31:0] FILL_DATA,
  input wire logic MOD_SET,
  input wire logic [`WBC_IDX_W-1:0] MOD_IDX,
  input wire logic [`WBC_ADDR_W-1:0] MOD_LINE_ADDR,
  input wire logic [127:0] MOD_LINE_DATA,
  output logic BUSY,
  input wire logic EXTERNAL_SNOOP_STROBE_N,
  input wire logic [`WBC_ADDR_W-1:0] SNOOP_LINE_ADDR,
  output logic MODIFIED_HIT_OUT_N,
  input wire logic BURST_READY_IN_N,
  input wire logic READY_IN_N,
  input wire logic BACKOFF_IN_N,
  input wire logic HOLD_IN,
  output logic HOLD_ACK_OUT,
  output logic ADDRESS_STROBE_OUT_N,
  output logic LAST_TRANSFER_OUT_N,
  output logic [29:0] ADDR_OUT,
  output logic [3:0] BYTE_LANE_ENABLES_N,
  output logic MEM_IO_OUT,
  output logic DATA_CODE_OUT,
  output logic WRITE_READ_OUT,
  output logic [31:0] DATA_OUT,
  output logic DATA_OUT_EN,
  input wire logic [31:0] DATA_IN,
  output logic CACHE_OUT_N,
  output logic CACHE_OUT_EN
);
  import wbc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SCAN, ST_CB_ADS, ST_CB_DATA, ST_FILL_ADS, ST_FILL_DATA,
    ST_SP1_ADS, ST_SP1_WAIT, ST_SP2_ADS, ST_SP2_WAIT, ST_OFF
  } wbc_state_type;

  function automatic logic snoop_match(input logic [`WBC_ADDR_W-1:0] a,
                                       input logic [`WBC_ADDR_W-1:0] b);
    snoop_match = (a == b);
  endfunction

  // Pins from the system bus are synchronised before use
  logic external_snoop_strobe_s, burst_ready_in_s, rdy_s, backoff_in_s, flush_s, ken_s, hold_s;
  wbc_sync u_s0 (.clk(CLK_SYS), .srst(SRST), .d(~EXTERNAL_SNOOP_STROBE_N), .q(external_snoop_strobe_s));
  wbc_sync u_s1 (.clk(CLK_SYS), .srst(SRST), .d(~BURST_READY_IN_N), .q(burst_ready_in_s));
  wbc_sync u_s2 (.clk(CLK_SYS), .srst(SRST), .d(~READY_IN_N), .q(rdy_s));
  wbc_sync u_s3 (.clk(CLK_SYS), .srst(SRST), .d(~BACKOFF_IN_N), .q(backoff_in_s));
  wbc_sync u_s4 (.clk(CLK_SYS), .srst(SRST), .d(~FLUSH_N), .q(flush_s));
  wbc_sync u_s5 (.clk(CLK_SYS), .srst(SRST), .d(~CACHEABLE_ENABLE_IN_N), .q(ken_s));
  wbc_sync u_s6 (.clk(CLK_SYS), .srst(SRST), .d(HOLD_IN), .q(hold_s));

  wbc_state_type st_q, resume_q;
  wbc_cyc_type cyc_q;
  logic [`WBC_LINES-1:0] mod_q;
  logic [`WBC_ADDR_W-1:0] line_addr_q [`WBC_LINES];
  logic [127:0] line_data_q [`WBC_LINES];
  logic [`WBC_IDX_W-1:0] cb_idx_q;
  logic [`WBC_ADDR_W-1:0] cb_addr_q, fill_addr_q;
  logic [127:0] cb_buf_q;
  logic [2:0] word_q;
  logic single_q, first_rdy_q, cb_live_q, modified_hit_out_q, fill_bad_q;
  logic flush_req_q, flush_prev_q, wbinv_q, inv_only_q, hw_flush_q, scan_start_q;
  logic scan_done;
  logic [`WBC_IDX_W-1:0] next_mod;
  logic any_mod, any_rdy, last_word, snoop_cb, snoop_line;
  logic [`WBC_IDX_W-1:0] snoop_idx;

  wbc_scan_timer #(.SCAN_CLKS(SCAN_CLKS)) u_scan (
    .clk(CLK_SYS), .srst(SRST), .start(scan_start_q), .done(scan_done)
  );

  always_comb begin
    next_mod = '0;
    any_mod = 1'b0;
    for (int i = `WBC_LINES - 1; i >= 0; i--) begin
      if (mod_q[i]) begin
        next_mod = `WBC_IDX_W'(i);
        any_mod = 1'b1;
      end
    end
  end

  // Snoop against lines still held in the array
  always_comb begin
    snoop_line = 1'b0;
    snoop_idx = '0;
    for (int i = 0; i < `WBC_LINES; i++) begin
      if (mod_q[i] && snoop_match(line_addr_q[i], SNOOP_LINE_ADDR)) begin
        snoop_line = 1'b1;
        snoop_idx = `WBC_IDX_W'(i);
      end
    end
  end

  assign any_rdy = burst_ready_in_s | rdy_s;
  assign last_word = (word_q == 3'h3);
  // Buffer answers snoops until its last ready is taken
  assign snoop_cb = external_snoop_strobe_s && cb_live_q && snoop_match(cb_addr_q, SNOOP_LINE_ADDR);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      flush_prev_q <= 1'b0;
      flush_req_q <= 1'b0;
    end else begin
      flush_prev_q <= flush_s;
      // Edge request held until the sequence takes it
      if (flush_s && !flush_prev_q)
        flush_req_q <= 1'b1;
      // Idle takes a snoop copy-back first, so the request must survive it
      else if (st_q == ST_IDLE && !(external_snoop_strobe_s && snoop_line))
        flush_req_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      mod_q <= '0;
      for (int i = 0; i < `WBC_LINES; i++) begin
        line_addr_q[i] <= '0;
        line_data_q[i] <= '0;
      end
    end else begin
      if (st_q == ST_SCAN && inv_only_q)
        mod_q <= '0;
      else if (st_q == ST_SCAN && any_mod && !cb_live_q)
        mod_q[next_mod] <= 1'b0;
      else if (external_snoop_strobe_s && snoop_line && !cb_live_q && st_q == ST_IDLE)
        mod_q[snoop_idx] <= 1'b0;
      // New modified data wins over a clear in the same cycle
      if (MOD_SET) begin
        mod_q[MOD_IDX] <= 1'b1;
        line_addr_q[MOD_IDX] <= MOD_LINE_ADDR;
        line_data_q[MOD_IDX] <= MOD_LINE_DATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_q <= ST_IDLE;
      resume_q <= ST_IDLE;
      cyc_q <= WBC_CYC_NONE;
      cb_idx_q <= '0;
      cb_addr_q <= '0;
      cb_buf_q <= '0;
      cb_live_q <= 1'b0;
      word_q <= 3'h0;
      single_q <= 1'b0;
      first_rdy_q <= 1'b0;
      wbinv_q <= 1'b0;
      inv_only_q <= 1'b0;
      hw_flush_q <= 1'b0;
      scan_start_q <= 1'b0;
      fill_addr_q <= '0;
    end else begin
      scan_start_q <= 1'b0;
      if (backoff_in_s && st_q != ST_IDLE && st_q != ST_SCAN && st_q != ST_OFF) begin
        resume_q <= (st_q == ST_CB_DATA) ? ST_CB_ADS :
                    (st_q == ST_FILL_DATA) ? ST_FILL_ADS :
                    (st_q == ST_SP1_WAIT) ? ST_SP1_ADS :
                    (st_q == ST_SP2_WAIT) ? ST_SP2_ADS : st_q;
        st_q <= ST_OFF;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (external_snoop_strobe_s && snoop_line) begin
              cb_idx_q <= snoop_idx;
              cb_addr_q <= line_addr_q[snoop_idx];
              cb_buf_q <= line_data_q[snoop_idx];
              cb_live_q <= 1'b1;
              word_q <= 3'h0;
              single_q <= 1'b0;
              st_q <= ST_CB_ADS;
            end else if (flush_req_q || WRITEBACK_INVALIDATE_INSTR || INVALIDATE_INSTR) begin
              hw_flush_q <= flush_req_q;
              inv_only_q <= !flush_req_q && INVALIDATE_INSTR && !WRITEBACK_INVALIDATE_INSTR;
              wbinv_q <= 1'b1;
              scan_start_q <= 1'b1;
              st_q <= ST_SCAN;
            end else if (FILL_REQ) begin
              fill_addr_q <= FILL_LINE_ADDR;
              word_q <= 3'h0;
              single_q <= 1'b0;
              st_q <= ST_FILL_ADS;
            end
          end
          ST_SCAN: begin
            // Nothing but reset leaves the scan early
            if (!inv_only_q && any_mod && !cb_live_q) begin
              cb_idx_q <= next_mod;
              cb_addr_q <= line_addr_q[next_mod];
              cb_buf_q <= line_data_q[next_mod];
              cb_live_q <= 1'b1;
              word_q <= 3'h0;
              single_q <= 1'b0;
              st_q <= ST_CB_ADS;
            end else if (scan_done && (inv_only_q || !any_mod)) begin
              st_q <= inv_only_q ? ST_SP2_ADS : ST_SP1_ADS;
            end
          end
          ST_CB_ADS: begin
            cyc_q <= WBC_CYC_COPYBACK;
            first_rdy_q <= 1'b0;
            st_q <= ST_CB_DATA;
          end
          ST_CB_DATA: begin
            if (any_rdy) begin
              first_rdy_q <= 1'b1;
              word_q <= word_q + 3'h1;
              if (rdy_s && !last_word) begin
                single_q <= 1'b1;
                st_q <= ST_CB_ADS;
              end
              if (last_word) begin
                cb_live_q <= 1'b0;
                cyc_q <= WBC_CYC_NONE;
                st_q <= wbinv_q ? ST_SCAN : ST_IDLE;
              end
            end
          end
          ST_FILL_ADS: begin
            cyc_q <= (FILL_CACHEABLE && ken_s) ? WBC_CYC_FILL : WBC_CYC_NONCACHE;
            first_rdy_q <= 1'b0;
            st_q <= ST_FILL_DATA;
          end
          ST_FILL_DATA: begin
            if (any_rdy) begin
              first_rdy_q <= 1'b1;
              word_q <= word_q + 3'h1;
              if (rdy_s && !last_word) begin
                single_q <= 1'b1;
                st_q <= ST_FILL_ADS;
              end
              // Non-cacheable read is one transfer, sent with last already low
              if (last_word || cyc_q == WBC_CYC_NONCACHE) begin
                cyc_q <= WBC_CYC_NONE;
                st_q <= ST_IDLE;
              end
            end
          end
          ST_SP1_ADS: begin
            cyc_q <= WBC_CYC_SPECIAL;
            st_q <= ST_SP1_WAIT;
          end
          ST_SP1_WAIT: begin
            if (any_rdy)
              st_q <= ST_SP2_ADS;
          end
          ST_SP2_ADS: begin
            cyc_q <= WBC_CYC_SPECIAL;
            st_q <= ST_SP2_WAIT;
          end
          ST_SP2_WAIT: begin
            if (any_rdy) begin
              cyc_q <= WBC_CYC_NONE;
              wbinv_q <= 1'b0;
              inv_only_q <= 1'b0;
              hw_flush_q <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
          ST_OFF: begin
            if (!backoff_in_s)
              st_q <= resume_q;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Fill discard tracking
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      fill_bad_q <= 1'b0;
    end else if (st_q == ST_FILL_ADS && word_q == 3'h0) begin
      fill_bad_q <= 1'b0;
    end else if (st_q == ST_FILL_DATA && external_snoop_strobe_s) begin
      if (snoop_match(SNOOP_LINE_ADDR, fill_addr_q))
        fill_bad_q <= 1'b1;
      else if (!first_rdy_q || (any_rdy && last_word))
        fill_bad_q <= 1'b1;
    end
  end

  // Read data staged to line up with the synchronised ready
  logic [31:0] din_s1_q, din_s2_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      din_s1_q <= 32'h00000000;
      din_s2_q <= 32'h00000000;
    end else begin
      din_s1_q <= DATA_IN;
      din_s2_q <= din_s1_q;
    end
  end

  // Line fill data to the core always, storage only if clean
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      FILL_DATA_VALID <= 1'b0;
      FILL_STORE <= 1'b0;
      FILL_DISCARD <= 1'b0;
      FILL_DATA <= 32'h00000000;
    end else begin
      FILL_DATA_VALID <= (st_q == ST_FILL_DATA) && any_rdy && !backoff_in_s;
      FILL_DATA <= din_s2_q;
      FILL_STORE <= 1'b0;
      FILL_DISCARD <= 1'b0;
      if (st_q == ST_FILL_DATA && any_rdy && last_word && !backoff_in_s) begin
        if (fill_bad_q || external_snoop_strobe_s || cyc_q != WBC_CYC_FILL)
          FILL_DISCARD <= 1'b1;
        else
          FILL_STORE <= 1'b1;
      end
    end
  end

  // Modified hit held until the final ready of the copy-back
  always_ff @(posedge CLK_SYS) begin
    if (SRST)
      modified_hit_out_q <= 1'b0;
    else if (snoop_cb || (external_snoop_strobe_s && snoop_line))
      modified_hit_out_q <= 1'b1;
    else if (st_q == ST_CB_DATA && any_rdy && last_word)
      modified_hit_out_q <= 1'b0;
  end
  assign MODIFIED_HIT_OUT_N = ~modified_hit_out_q;

  // Bus drive
  logic drive;
  logic cache_valid_q;
  assign drive = (st_q != ST_OFF) && !HOLD_ACK_OUT;
  always_ff @(posedge CLK_SYS) begin
    if (SRST)
      HOLD_ACK_OUT <= 1'b0;
    else
      HOLD_ACK_OUT <= hold_s && (st_q == ST_IDLE || st_q == ST_SCAN);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ADDRESS_STROBE_OUT_N <= 1'b1;
      LAST_TRANSFER_OUT_N <= 1'b1;
      ADDR_OUT <= 30'h00000000;
      BYTE_LANE_ENABLES_N <= 4'hf;
      MEM_IO_OUT <= 1'b0;
      DATA_CODE_OUT <= 1'b0;
      WRITE_READ_OUT <= 1'b0;
      DATA_OUT <= 32'h00000000;
      DATA_OUT_EN <= 1'b0;
    end else begin
      ADDRESS_STROBE_OUT_N <= 1'b1;
      DATA_OUT_EN <= 1'b0;
      case (st_q)
        ST_CB_ADS: begin
          ADDRESS_STROBE_OUT_N <= 1'b0;
          ADDR_OUT <= {cb_addr_q, word_q[1:0]};
          BYTE_LANE_ENABLES_N <= 4'h0;
          MEM_IO_OUT <= 1'b1;
          DATA_CODE_OUT <= 1'b1;
          WRITE_READ_OUT <= 1'b1;
          DATA_OUT <= cb_buf_q[32*word_q[1:0] +: 32];
          DATA_OUT_EN <= 1'b1;
          LAST_TRANSFER_OUT_N <= !(single_q || word_q == 3'h3);
        end
        ST_CB_DATA: begin
          DATA_OUT_EN <= 1'b1;
          if (any_rdy && !last_word) begin
            ADDR_OUT <= {cb_addr_q, word_q[1:0] + 2'h1};
            DATA_OUT <= cb_buf_q[32*(word_q[1:0] + 2'h1) +: 32];
            LAST_TRANSFER_OUT_N <= !(word_q == 3'h2);
          end
        end
        ST_FILL_ADS: begin
          ADDRESS_STROBE_OUT_N <= 1'b0;
          ADDR_OUT <= {fill_addr_q, word_q[1:0]};
          BYTE_LANE_ENABLES_N <= 4'h0;
          MEM_IO_OUT <= 1'b1;
          DATA_CODE_OUT <= 1'b1;
          WRITE_READ_OUT <= 1'b0;
          LAST_TRANSFER_OUT_N <= !(single_q || word_q == 3'h3 || !(FILL_CACHEABLE && ken_s));
        end
        ST_FILL_DATA: begin
          if (any_rdy && !last_word) begin
            ADDR_OUT <= {fill_addr_q, word_q[1:0] + 2'h1};
            LAST_TRANSFER_OUT_N <= !(word_q == 3'h2);
          end
        end
        ST_SP1_ADS, ST_SP2_ADS: begin
          ADDRESS_STROBE_OUT_N <= 1'b0;
          ADDR_OUT <= {2'h0, hw_flush_q ? `WBC_SPECIAL_ADDR_FA : `WBC_SPECIAL_ADDR_WB};
          BYTE_LANE_ENABLES_N <= (st_q == ST_SP1_ADS) ? `WBC_BE_FIRST : `WBC_BE_SECOND;
          MEM_IO_OUT <= 1'b0;
          DATA_CODE_OUT <= 1'b0;
          WRITE_READ_OUT <= 1'b1;
          LAST_TRANSFER_OUT_N <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Cache indicator: active for cacheable fills and copy-backs
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      CACHE_OUT_N <= 1'b1;
      cache_valid_q <= 1'b0;
    end else begin
      if (st_q == ST_CB_ADS) begin
        CACHE_OUT_N <= 1'b0;
        cache_valid_q <= 1'b1;
      end else if (st_q == ST_FILL_ADS) begin
        CACHE_OUT_N <= !(FILL_CACHEABLE && ken_s);
        cache_valid_q <= 1'b1;
      end else if (st_q == ST_SP1_ADS || st_q == ST_SP2_ADS) begin
        CACHE_OUT_N <= 1'b1;
        cache_valid_q <= 1'b1;
      end else if (any_rdy) begin
        CACHE_OUT_N <= 1'b1;
      end
    end
  end
  assign CACHE_OUT_EN = WRITEBACK_MODE && cache_valid_q && drive;

  assign BUSY = (st_q != ST_IDLE);
endmodule

// >>> wbc_monitor.sv
`timescale 1ns/1ps
module wbc_monitor #(
  parameter int SCAN_CLKS = 4100
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic WRITEBACK_MODE,
  input wire logic BACKOFF_IN_N,
  input wire logic BURST_READY_IN_N,
  input wire logic READY_IN_N,
  input wire logic MODIFIED_HIT_OUT_N,
  input wire logic HOLD_ACK_OUT,
  input wire logic ADDRESS_STROBE_OUT_N,
  input wire logic LAST_TRANSFER_OUT_N,
  input wire logic [29:0] ADDR_OUT,
  input wire logic [3:0] BYTE_LANE_ENABLES_N,
  input wire logic MEM_IO_OUT,
  input wire logic DATA_CODE_OUT,
  input wire logic WRITE_READ_OUT,
  input wire logic CACHE_OUT_N,
  input wire logic CACHE_OUT_EN
);
  logic [3:0] since_q;
  logic st;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  assign st = !ADDRESS_STROBE_OUT_N;
  // Pins are synced inside, so hit may clear a few clocks after the final ready
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      since_q <= 4'hf;
    end else if (!LAST_TRANSFER_OUT_N && !(BURST_READY_IN_N && READY_IN_N)) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hf) begin
      since_q <= since_q + 4'h1;
    end
  end
  wb_special_a:
    assert property (st && !MEM_IO_OUT && BYTE_LANE_ENABLES_N == 4'h7 |->
      !DATA_CODE_OUT && WRITE_READ_OUT && ADDR_OUT[29:1] == 29'h0) else $error("bad first special");
  flush_special_a:
    assert property (st && !MEM_IO_OUT && BYTE_LANE_ENABLES_N == 4'hd |->
      !DATA_CODE_OUT && WRITE_READ_OUT && ADDR_OUT[29:1] == 29'h0) else $error("bad flush special");
  special_nocache_a:
    assert property (st && !MEM_IO_OUT |-> CACHE_OUT_N || !CACHE_OUT_EN)
      else $error("indicator active on special cycle");
  burst_start_a:
    assert property (st && MEM_IO_OUT && WRITE_READ_OUT && WRITEBACK_MODE && ADDR_OUT[1:0] == 2'h0
      |-> BYTE_LANE_ENABLES_N == 4'h0 && !CACHE_OUT_N && CACHE_OUT_EN ##1 LAST_TRANSFER_OUT_N)
      else $error("bad burst write start");
  wt_float_a:
    assert property (!WRITEBACK_MODE [*2] |-> !CACHE_OUT_EN) else $error("indicator driven in wt");
  hold_float_a:
    assert property (HOLD_ACK_OUT |-> !CACHE_OUT_EN && !st) else $error("bus driven in hold");
  modified_hit_out_hold_a:
    assert property ($rose(MODIFIED_HIT_OUT_N) |-> since_q <= 4'h5)
      else $error("hit released before final ready");
  backoff_float_a:
    assert property (!BACKOFF_IN_N [*5] |-> !CACHE_OUT_EN && !st) else $error("bus kept in backoff");
  cover property (st && !MEM_IO_OUT);
  cover property ($fell(MODIFIED_HIT_OUT_N));
  cover property (!BACKOFF_IN_N [*5]);
endmodule
bind wbc_top wbc_monitor #(.SCAN_CLKS(SCAN_CLKS)) i_mon (.*);

// >>> wbc_sys_model.sv
`timescale 1ns/1ps
module wbc_sys_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic strobe_n,
  input wire logic last_n,
  input wire logic mem_io,
  input wire logic backoff_n,
  input wire logic nb,
  input wire logic [3:0] lat,
  output logic burst_ready_in_n,
  output logic rdy_n,
  output logic [31:0] data
);
  logic act_q;
  logic [3:0] cnt_q;
  logic [7:0] word_q;
  // Lat below 3 would outrun the two-stage input sync of the device
  always_ff @(posedge clk) begin
    if (srst) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
      word_q <= 8'h0;
      burst_ready_in_n <= 1'b1;
      rdy_n <= 1'b1;
      data <= 32'h0;
    end else begin
      burst_ready_in_n <= 1'b1;
      rdy_n <= 1'b1;
      data <= ~data;
      if (!strobe_n) begin
        act_q <= 1'b1;
        cnt_q <= lat;
      end else if (act_q && !backoff_n) begin
        act_q <= 1'b0;
      end else if (act_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (act_q) begin
        if (nb || !mem_io) rdy_n <= 1'b0;
        else burst_ready_in_n <= 1'b0;
        data <= {24'h5a5a5a, word_q};
        word_q <= word_q + 8'h1;
        if (nb || !mem_io || !last_n) act_q <= 1'b0;
        else cnt_q <= lat;
      end
    end
  end
endmodule

// >>> test_writeback_cache_bus_snoop_flush.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(64'(g), 64'(e));
module test_writeback_cache_bus_snoop_flush;
  localparam logic [27:0] LA = 28'h0123450;
  logic CLK_SYS = 1'b0, SRST = 1'b1, WRITEBACK_MODE = 1'b1, WRITEBACK_INVALIDATE_INSTR = 1'b0;
  logic INVALIDATE_INSTR = 1'b0, FLUSH_N = 1'b1, FILL_REQ = 1'b0, FILL_CACHEABLE = 1'b0;
  logic CACHEABLE_ENABLE_IN_N = 1'b1, MOD_SET = 1'b0, EXTERNAL_SNOOP_STROBE_N = 1'b1;
  logic BACKOFF_IN_N = 1'b1, HOLD_IN = 1'b0, nb = 1'b0;
  logic [27:0] FILL_LINE_ADDR = 28'h0, MOD_LINE_ADDR = 28'h0, SNOOP_LINE_ADDR = 28'h0;
  logic [3:0] MOD_IDX = 4'h0, lat = 4'h4;
  logic [127:0] MOD_LINE_DATA = 128'h0;
  logic BURST_READY_IN_N, READY_IN_N, FILL_DATA_VALID, FILL_STORE, FILL_DISCARD, BUSY;
  logic MODIFIED_HIT_OUT_N, HOLD_ACK_OUT, ADDRESS_STROBE_OUT_N, LAST_TRANSFER_OUT_N, MEM_IO_OUT;
  logic DATA_CODE_OUT, WRITE_READ_OUT, DATA_OUT_EN, CACHE_OUT_N, CACHE_OUT_EN, hit, fc, fe;
  logic [31:0] DATA_IN, FILL_DATA, DATA_OUT;
  logic [29:0] ADDR_OUT;
  logic [3:0] BYTE_LANE_ENABLES_N;
  logic [33:0] bq[$];
  logic [36:0] spq[$];
  logic [31:0] dq[$];
  int mismatches = 0, tests_run = 0, cyc = 0, sp_t = 0, nv = 0, ns = 0, nd = 0, nf = 0;

  wbc_top #(.SCAN_CLKS(16)) i_dut (.*);
  wbc_sys_model i_sys (.clk(CLK_SYS), .srst(SRST), .strobe_n(ADDRESS_STROBE_OUT_N),
    .last_n(LAST_TRANSFER_OUT_N), .mem_io(MEM_IO_OUT), .backoff_n(BACKOFF_IN_N), .nb(nb),
    .lat(lat), .burst_ready_in_n(BURST_READY_IN_N), .rdy_n(READY_IN_N), .data(DATA_IN));

  always #25 CLK_SYS = ~CLK_SYS;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bus log, sampled before each edge lands
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      test_done();
    end
    if (!ADDRESS_STROBE_OUT_N && !MEM_IO_OUT) begin
      spq.push_back({MEM_IO_OUT, DATA_CODE_OUT, WRITE_READ_OUT, ADDR_OUT, BYTE_LANE_ENABLES_N});
      if (sp_t == 0) sp_t = cyc;
    end else if (!ADDRESS_STROBE_OUT_N && WRITE_READ_OUT) begin
      bq.push_back({ADDR_OUT, BYTE_LANE_ENABLES_N});
    end else if (!ADDRESS_STROBE_OUT_N) begin
      fc = CACHE_OUT_N;
      fe = CACHE_OUT_EN;
    end
    if (MEM_IO_OUT && WRITE_READ_OUT && !(BURST_READY_IN_N && READY_IN_N)) dq.push_back(DATA_OUT);
    nv += FILL_DATA_VALID;
    ns += FILL_STORE;
    nd += FILL_DISCARD;
    nf += FILL_DATA_VALID && FILL_DATA[31:8] == 24'h5a5a5a;
    if (MODIFIED_HIT_OUT_N === 1'b0) hit = 1'b1;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge CLK_SYS);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && BUSY !== 1'b0; i++) tick();
    `CHK(BUSY, 1'b0)
  endtask

  task automatic snoop(input logic [27:0] a);
    SNOOP_LINE_ADDR <= a;
    EXTERNAL_SNOOP_STROBE_N <= 1'b0;
    tick();
    EXTERNAL_SNOOP_STROBE_N <= 1'b1;
  endtask

  task automatic wait_burst_ready_in();
    int i;
    for (i = 0; i < 500 && BURST_READY_IN_N !== 1'b0; i++) tick();
    tick();
  endtask

  // sm: 0 none, 1 same line early, 2 other line early, 3 other line mid-burst
  task automatic fill_run(input int sm, input bit cach, input bit st);
    int i;
    nv = 0;
    ns = 0;
    nd = 0;
    nf = 0;
    lat <= 4'h8;
    FILL_LINE_ADDR <= LA + 28'h40;
    FILL_CACHEABLE <= cach;
    // Cacheable pin needs its sync stages before the strobe state reads it
    CACHEABLE_ENABLE_IN_N <= !cach;
    tick(3);
    FILL_REQ <= 1'b1;
    for (i = 0; i < 100 && ADDRESS_STROBE_OUT_N !== 1'b0; i++) tick();
    FILL_REQ <= 1'b0;
    if (sm == 3) wait_burst_ready_in();
    if (sm != 0) snoop(sm == 1 ? LA + 28'h40 : LA + 28'h77);
    tick(4);
    wait_idle();
    tick(2);
    if (WRITEBACK_MODE) `CHK({fe, fc}, {1'b1, ~cach})
    else `CHK(fe, 1'b0)
    if (cach) begin
      `CHK(nv, 4)
      `CHK(nf, 4)
      `CHK(ns, st)
      `CHK(nd, !st)
    end
  endtask

  task automatic floats();
    int i;
    HOLD_IN <= 1'b1;
    for (i = 0; i < 20 && HOLD_ACK_OUT !== 1'b1; i++) tick();
    `CHK({HOLD_ACK_OUT, CACHE_OUT_EN}, 2'b10)
    HOLD_IN <= 1'b0;
    WRITEBACK_MODE <= 1'b0;
    tick(6);
    fill_run(0, 1, 1);
    WRITEBACK_MODE <= 1'b1;
    tick(2);
  endtask

  // how: 0 write-back-invalidate, 1 invalidate only, 2 flush pin
  task automatic flush_run(input int how, input int n, input bit nbm, input bit snp, input bit bo);
    int i, k, t0;
    logic [27:0] a;
    logic [29:0] sa;
    bq.delete();
    spq.delete();
    dq.delete();
    sp_t = 0;
    hit = 1'b0;
    nb <= nbm;
    lat <= 4'h4;
    for (i = 0; i < n; i++) begin
      a = LA + 28'(i);
      MOD_SET <= 1'b1;
      MOD_IDX <= 4'(i);
      MOD_LINE_ADDR <= a;
      MOD_LINE_DATA <= {4'h3, a, 4'h2, a, 4'h1, a, 4'h0, a};
      tick();
    end
    MOD_SET <= 1'b0;
    t0 = cyc;
    if (how == 0) WRITEBACK_INVALIDATE_INSTR <= 1'b1;
    else if (how == 1) INVALIDATE_INSTR <= 1'b1;
    else FLUSH_N <= 1'b0;
    tick();
    WRITEBACK_INVALIDATE_INSTR <= 1'b0;
    INVALIDATE_INSTR <= 1'b0;
    if (snp || bo) wait_burst_ready_in();
    if (snp) snoop(LA);
    if (bo) BACKOFF_IN_N <= 1'b0;
    tick(6);
    BACKOFF_IN_N <= 1'b1;
    wait_idle();
    FLUSH_N <= 1'b1;
    tick(4);
    sa = (how == 2) ? 30'h1 : 30'h0;
    if (!bo) `CHK(bq.size(), how == 1 ? 0 : n * (nbm ? 4 : 1))
    `CHK(dq.size(), how == 1 ? 0 : 4 * n)
    for (i = 0; i < n && how != 1; i++) begin
      for (k = 0; k < 4; k++) begin
        if (!bo && (nbm || k == 0)) `CHK(bq.pop_front(), {LA + 28'(i), (nbm ? 2'(k) : 2'h0), 4'h0})
        `CHK(dq.pop_front(), {4'(k), LA + 28'(i)})
      end
    end
    `CHK(spq.size(), how == 1 ? 1 : 2)
    if (how != 1) `CHK(spq.pop_front(), {3'b001, sa, 4'h7})
    `CHK(spq.pop_front(), {3'b001, sa, 4'hd})
    if (how != 1) `CHK(sp_t - t0 >= 16, 1'b1)
    if (snp) `CHK(hit, 1'b1)
  endtask

  initial begin
    tick(5);
    SRST <= 1'b0;
    tick(3);
    fill_run(0, 1, 1);
    fill_run(1, 1, 0);
    fill_run(2, 1, 0);
    fill_run(3, 1, 1);
    fill_run(0, 0, 0);
    floats();
    flush_run(0, 2, 0, 1, 0);
    flush_run(1, 1, 0, 0, 0);
    flush_run(2, 2, 0, 0, 1);
    flush_run(0, 1, 1, 0, 0);
    test_done();
  end
endmodule
